// file: rtl/swu_byte_tx.sv
// Purpose: sends one framed byte at the measured bit time
// Assumes: bit_cycles stays stable while busy
// Notes: line level rests high between bytes
`timescale 1ns/1ps
module swu_byte_tx #(
    parameter int BW = 14
) (
    input wire logic core_clk,
    input wire logic arst_n,
    swu_tx_if.tx tx
);
    logic [8:0] sh_q;
    logic [3:0] cnt_q;
    logic [BW-1:0] tmr_q;
    logic busy_q;
    logic done_q;
    logic txd_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sh_q <= 9'h1FF;
            cnt_q <= 4'h0;
            tmr_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            txd_q <= 1'b1;
        end else begin
            done_q <= 1'b0;
            if (tx.start && !busy_q) begin
                txd_q <= 1'b0;
                sh_q <= {1'b1, tx.data};
                cnt_q <= swu_pkg::SWU_FRAME_BITS;
                tmr_q <= tx.bit_cycles - 1'b1;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (tmr_q == '0) begin
                    if (cnt_q == 4'h0) begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                    end else begin
                        txd_q <= sh_q[0];
                        sh_q <= {1'b1, sh_q[8:1]};
                        cnt_q <= cnt_q - 4'h1;
                        tmr_q <= tx.bit_cycles - 1'b1;
                    end
                end else begin
                    tmr_q <= tmr_q - 1'b1;
                end
            end
        end
    end

    assign tx.busy = busy_q;
    assign tx.done = done_q;
    assign tx.txd = txd_q;
endmodule : swu_byte_tx

// file: rtl/swu_pkg.sv
// Purpose: shared constants and types of the single-wire datagram port
// Assumes: 8 data bits, one start and one stop bit per byte
// Notes: bit counts are in bit times, cycle counts in core_clk cycles
package swu_pkg;
    localparam logic [3:0] SWU_SYNC_NIBBLE = 4'h5;
    localparam logic [7:0] SWU_SYNC_TX_BYTE = 8'h05;
    localparam logic [7:0] SWU_MASTER_ADDR = 8'hFF;
    localparam int SWU_RW_BIT = 7;
    localparam logic [7:0] SWU_CRC_POLY = 8'h07;
    localparam logic [7:0] SWU_CRC_INIT = 8'h00;
    localparam logic [7:0] SWU_TIMEOUT_BITS = 8'h3F;
    localparam logic [7:0] SWU_RECOVER_BITS = 8'h0C;
    localparam logic [7:0] SWU_GLITCH_CYC = 8'h10;
    localparam logic [7:0] SWU_HOLD_BITS = 8'h04;
    localparam logic [7:0] SWU_DELAY_STEP_BITS = 8'h08;
    localparam logic [2:0] SWU_LAST_RD_BYTE = 3'h3;
    localparam logic [2:0] SWU_LAST_WR_BYTE = 3'h7;
    localparam logic [3:0] SWU_SYNC_FIRST_IDX = 4'h4;
    localparam logic [3:0] SWU_FRAME_BITS = 4'h9;

    typedef enum logic [9:0] {
        ST_IDLE  = 10'h001,
        ST_SYNC  = 10'h002,
        ST_START = 10'h004,
        ST_BITS  = 10'h008,
        ST_STOP  = 10'h010,
        ST_GAP   = 10'h020,
        ST_RECOV = 10'h040,
        ST_TURN  = 10'h080,
        ST_SEND  = 10'h100,
        ST_HOLD  = 10'h200
    } swu_state_t;

    // lsb-first serial crc, one byte per call
    function automatic logic [7:0] swu_crc8(input logic [7:0] crc_in, input logic [7:0] din);
        logic [7:0] c;
        c = crc_in;
        for (int i = 0; i < 8; i++) begin
            if (c[7] ^ din[i]) begin
                c = {c[6:0], 1'b0} ^ SWU_CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction : swu_crc8
endpackage : swu_pkg

// file: rtl/swu_port.sv
// Purpose: single-wire half-duplex datagram port, node side
// Assumes: core_clk 50 MHz, line pulled high outside frames
// Notes: register contents live outside, reached by the strobes below
`timescale 1ns/1ps
module swu_port #(
    parameter int BW = 14,
    parameter int TW = 20
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic line_in,
    output logic line_out,
    output logic line_oe,
    input wire logic address_strap_low,
    input wire logic address_strap_high,
    input wire logic [3:0] reply_turnaround_delay,
    input wire logic pdn_disable,
    input wire logic reg_power_down,
    output logic power_down,
    output logic wr_strobe,
    output logic rd_strobe,
    output logic [6:0] reg_addr,
    output logic [31:0] wr_data,
    input wire logic [31:0] rd_data,
    output logic [7:0] write_count,
    output logic link_error
);
    swu_pkg::swu_state_t state_q;
    logic [2:0] ls_q;
    logic rx_q, rx_prev_q;
    logic [1:0] a1_q, a2_q, a3_q, node_q;
    logic [TW-1:0] tmr_q, meas_q, tmo_q;
    logic [BW-1:0] bit_q, good_q;
    logic [3:0] idx_q;
    logic edge_q;
    logic [7:0] byte_q, crc_q, addr_q, reg_q, tx_crc_q, tx_byte;
    logic [2:0] nbyte_q, tx_idx_q;
    logic [31:0] data_q, rdat_q;
    logic wr_q, rd_q, err_q, oe_q, pd_q, tx_start_q, issued_q;
    logic fall, rise, last_byte, rx_active, tmo_hit;
    logic [7:0] new_crc;
    logic [3:0] dly_steps;

    swu_tx_if #(.BW(BW)) txb ();

    swu_byte_tx #(.BW(BW)) u_tx (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .tx(txb)
    );

    function automatic logic [TW-1:0] bits_to_cyc(input logic [BW-1:0] b, input logic [7:0] n);
        logic [TW-1:0] wb;
        logic [TW-1:0] wn;
        wb = TW'(b);
        wn = TW'(n);
        return wb * wn;
    endfunction : bits_to_cyc

    // three flops; a level counts once stages two and three agree
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ls_q <= 3'h7;
            rx_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end else begin
            ls_q <= {ls_q[1:0], line_in};
            if (ls_q[1] == ls_q[2]) begin
                rx_q <= ls_q[1];
            end
            rx_prev_q <= rx_q;
        end
    end

    // straps synchronised, address follows settled value
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            a1_q <= 2'h0;
            a2_q <= 2'h0;
            a3_q <= 2'h0;
            node_q <= 2'h0;
        end else begin
            a1_q <= {address_strap_high, address_strap_low};
            a2_q <= a1_q;
            a3_q <= a2_q;
            if (a2_q == a3_q) begin
                node_q <= a2_q;
            end
        end
    end

    assign fall = rx_prev_q & ~rx_q;
    assign rise = ~rx_prev_q & rx_q;
    assign rx_active = (state_q == swu_pkg::ST_SYNC) || (state_q == swu_pkg::ST_START) ||
        (state_q == swu_pkg::ST_BITS) || (state_q == swu_pkg::ST_STOP) || (state_q == swu_pkg::ST_GAP);
    assign new_crc = swu_pkg::swu_crc8(crc_q, byte_q);
    // read request ends after its fourth byte
    assign last_byte = (nbyte_q == swu_pkg::SWU_LAST_WR_BYTE) ||
        (nbyte_q == swu_pkg::SWU_LAST_RD_BYTE && !reg_q[swu_pkg::SWU_RW_BIT]);
    // setting zero still gives one step of eight bit times
    assign dly_steps = (reply_turnaround_delay == 4'h0) ? 4'h1 : reply_turnaround_delay;

    // time since the last falling edge, judged with last good bit time
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tmo_q <= '0;
        end else if (!rx_active || fall) begin
            tmo_q <= '0;
        end else if (tmo_q != '1) begin
            tmo_q <= tmo_q + 1'b1;
        end
    end
    assign tmo_hit = tmo_q > bits_to_cyc(good_q, swu_pkg::SWU_TIMEOUT_BITS);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= swu_pkg::ST_IDLE;
            tmr_q <= '0;
            meas_q <= '0;
            bit_q <= '1;
            good_q <= '1;
            idx_q <= 4'h0;
            edge_q <= 1'b0;
            byte_q <= 8'h00;
            crc_q <= swu_pkg::SWU_CRC_INIT;
            nbyte_q <= 3'h0;
            addr_q <= 8'h00;
            reg_q <= 8'h00;
            data_q <= 32'h0000_0000;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            err_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            err_q <= 1'b0;
            if (rx_active && tmo_hit) begin
                err_q <= 1'b1;
                tmr_q <= '0;
                state_q <= swu_pkg::ST_RECOV;
            end else begin
                unique case (state_q)
                    swu_pkg::ST_IDLE: begin
                        if (fall) begin
                            meas_q <= TW'(1);
                            edge_q <= 1'b0;
                            state_q <= swu_pkg::ST_SYNC;
                        end
                    end
                    swu_pkg::ST_SYNC: begin
                        meas_q <= meas_q + 1'b1;
                        if (rise && meas_q < TW'(swu_pkg::SWU_GLITCH_CYC)) begin
                            // short idle-line pulse is a glitch
                            err_q <= 1'b1;
                            tmr_q <= '0;
                            state_q <= swu_pkg::ST_RECOV;
                        end else if (fall && !edge_q) begin
                            edge_q <= 1'b1;
                        end else if (fall) begin
                            // four bit times measured, retune divider
                            bit_q <= meas_q[BW+1:2];
                            tmr_q <= TW'(meas_q[BW+1:2]) + TW'(meas_q[BW+1:3]) - 1'b1;
                            // low nibble taken as sync; upper bits sampled, not checked
                            byte_q <= {4'h0, swu_pkg::SWU_SYNC_NIBBLE};
                            idx_q <= swu_pkg::SWU_SYNC_FIRST_IDX;
                            nbyte_q <= 3'h0;
                            crc_q <= swu_pkg::SWU_CRC_INIT;
                            state_q <= swu_pkg::ST_BITS;
                        end
                    end
                    swu_pkg::ST_GAP: begin
                        if (fall) begin
                            tmr_q <= TW'(bit_q[BW-1:1]);
                            state_q <= swu_pkg::ST_START;
                        end
                    end
                    swu_pkg::ST_START: begin
                        if (tmr_q != '0) begin
                            tmr_q <= tmr_q - 1'b1;
                        end else if (rx_q) begin
                            // false start bit is an error
                            err_q <= 1'b1;
                            state_q <= swu_pkg::ST_RECOV;
                        end else begin
                            tmr_q <= TW'(bit_q) - 1'b1;
                            idx_q <= 4'h0;
                            state_q <= swu_pkg::ST_BITS;
                        end
                    end
                    swu_pkg::ST_BITS: begin
                        if (tmr_q != '0) begin
                            tmr_q <= tmr_q - 1'b1;
                        end else begin
                            byte_q[idx_q[2:0]] <= rx_q;
                            tmr_q <= TW'(bit_q) - 1'b1;
                            idx_q <= idx_q + 4'h1;
                            if (idx_q[2:0] == 3'h7) begin
                                state_q <= swu_pkg::ST_STOP;
                            end
                        end
                    end
                    swu_pkg::ST_STOP: begin
                        if (tmr_q != '0) begin
                            tmr_q <= tmr_q - 1'b1;
                        end else if (!rx_q) begin
                            // missing stop bit treated like a glitch
                            err_q <= 1'b1;
                            state_q <= swu_pkg::ST_RECOV;
                        end else if (!last_byte) begin
                            // crc over every byte before the crc byte
                            crc_q <= new_crc;
                            nbyte_q <= nbyte_q + 3'h1;
                            if (nbyte_q == 3'h1) begin
                                addr_q <= byte_q;
                            end else if (nbyte_q == 3'h2) begin
                                reg_q <= byte_q;
                            end else if (nbyte_q != 3'h0) begin
                                data_q <= {data_q[23:0], byte_q};
                            end
                            state_q <= swu_pkg::ST_GAP;
                        end else if (byte_q != crc_q) begin
                            err_q <= 1'b1;
                            state_q <= swu_pkg::ST_RECOV;
                        end else begin
                            good_q <= bit_q;
                            tmr_q <= '0;
                            // only own address is acted on
                            if (addr_q != {6'h00, node_q}) begin
                                state_q <= swu_pkg::ST_IDLE;
                            end else if (reg_q[swu_pkg::SWU_RW_BIT]) begin
                                wr_q <= 1'b1;
                                state_q <= swu_pkg::ST_IDLE;
                            end else begin
                                rd_q <= 1'b1;
                                state_q <= swu_pkg::ST_TURN;
                            end
                        end
                    end
                    swu_pkg::ST_RECOV: begin
                        // wait for 12 idle bit times
                        if (!rx_q) begin
                            tmr_q <= '0;
                        end else if (tmr_q >= bits_to_cyc(good_q, swu_pkg::SWU_RECOVER_BITS)) begin
                            state_q <= swu_pkg::ST_IDLE;
                        end else begin
                            tmr_q <= tmr_q + 1'b1;
                        end
                    end
                    swu_pkg::ST_TURN: begin
                        if (tmr_q >= bits_to_cyc(bit_q, 8'({4'h0, dly_steps} * swu_pkg::SWU_DELAY_STEP_BITS))) begin
                            oe_q <= 1'b1;
                            state_q <= swu_pkg::ST_SEND;
                        end else begin
                            tmr_q <= tmr_q + 1'b1;
                        end
                    end
                    swu_pkg::ST_SEND: begin
                        if (txb.done && tx_idx_q == swu_pkg::SWU_LAST_WR_BYTE) begin
                            tmr_q <= '0;
                            state_q <= swu_pkg::ST_HOLD;
                        end
                    end
                    swu_pkg::ST_HOLD: begin
                        // release driver four bit times after stop bit
                        if (tmr_q >= bits_to_cyc(bit_q, swu_pkg::SWU_HOLD_BITS) - 1'b1) begin
                            oe_q <= 1'b0;
                            state_q <= swu_pkg::ST_IDLE;
                        end else begin
                            tmr_q <= tmr_q + 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // reply sequencing; own echo is not listened to while sending
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_idx_q <= 3'h0;
            tx_crc_q <= swu_pkg::SWU_CRC_INIT;
            tx_start_q <= 1'b0;
            issued_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            tx_start_q <= 1'b0;
            if (rd_q) begin
                rdat_q <= rd_data;
                tx_idx_q <= 3'h0;
                tx_crc_q <= swu_pkg::SWU_CRC_INIT;
                issued_q <= 1'b0;
            end else if (state_q == swu_pkg::ST_SEND) begin
                if (txb.done) begin
                    issued_q <= 1'b0;
                    tx_idx_q <= tx_idx_q + 3'h1;
                end else if (!issued_q && !txb.busy) begin
                    tx_start_q <= 1'b1;
                    issued_q <= 1'b1;
                    // reply crc accumulated as bytes leave
                    // crc byte left out, else it would fold into itself before it is sent
                    if (tx_idx_q != swu_pkg::SWU_LAST_WR_BYTE) begin
                        tx_crc_q <= swu_pkg::swu_crc8(tx_crc_q, tx_byte);
                    end
                end
            end
        end
    end

    // reply layout; reserved sync bits sent as zero
    always_comb begin
        unique case (tx_idx_q)
            3'h0: tx_byte = swu_pkg::SWU_SYNC_TX_BYTE;
            3'h1: tx_byte = swu_pkg::SWU_MASTER_ADDR;
            3'h2: tx_byte = {1'b0, reg_q[6:0]};
            3'h3: tx_byte = rdat_q[31:24];
            3'h4: tx_byte = rdat_q[23:16];
            3'h5: tx_byte = rdat_q[15:8];
            3'h6: tx_byte = rdat_q[7:0];
            3'h7: tx_byte = tx_crc_q;
        endcase
    end

    assign txb.start = tx_start_q;
    assign txb.data = tx_byte;
    // reply at the request's measured bit time
    assign txb.bit_cycles = bit_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            write_count <= 8'h00;
        end else if (wr_q) begin
            write_count <= write_count + 8'h01;
        end
    end

    // pin-level power-down only while not disabled
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pd_q <= 1'b0;
        end else begin
            pd_q <= pdn_disable ? reg_power_down : ~rx_q;
        end
    end

    // driven high whenever the reply driver is on but idle
    assign line_out = txb.txd;
    assign line_oe = oe_q;
    assign power_down = pd_q;
    assign wr_strobe = wr_q;
    assign rd_strobe = rd_q;
    assign reg_addr = reg_q[6:0];
    assign wr_data = data_q;
    assign link_error = err_q;
endmodule : swu_port

// file: rtl/swu_tx_if.sv
// Purpose: carrier between the datagram controller and its byte sender
// Assumes: single core_clk domain
// Notes: start is a one-cycle pulse, done pulses at end of stop bit
`timescale 1ns/1ps
interface swu_tx_if #(parameter int BW = 14);
    logic start;
    logic [7:0] data;
    logic [BW-1:0] bit_cycles;
    logic busy;
    logic done;
    logic txd;
    modport ctl (output start, output data, output bit_cycles, input busy, input done, input txd);
    modport tx (input start, input data, input bit_cycles, output busy, output done, output txd);
endinterface : swu_tx_if

// file: tb/swu_host.sv
// Purpose: host uart master model on the shared line
// Assumes: fixed bit time, one start and one stop bit
// Notes: host_txd high stands for the released, pulled-up line
`timescale 1ns/1ps
module swu_host #(
    parameter int BIT = 40
) (
    input wire logic core_clk,
    input wire logic line,
    output logic host_txd
);
    initial host_txd = 1'b1;
    function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            c = (c[7] ^ d[i]) ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
        end
        return c;
    endfunction : crc
    task automatic tx_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            host_txd <= f[i];
            repeat (BIT) @(posedge core_clk);
        end
    endtask : tx_byte
    // upper sync bits nonzero on purpose
    task automatic tx_dgram(input logic [7:0] a, input logic [7:0] r, input logic [31:0] d, input bit bad);
        logic [7:0] q[$];
        logic [7:0] c;
        q = {8'hA5, a, r};
        if (r[7]) q = {q, d[31:24], d[23:16], d[15:8], d[7:0]};
        c = 8'h00;
        foreach (q[i]) c = crc(c, q[i]);
        q.push_back(bad ? ~c : c);
        foreach (q[i]) tx_byte(q[i]);
    endtask : tx_dgram
    // short low pulse on idle line
    task automatic pulse(input int n);
        host_txd <= 1'b0;
        repeat (n) @(posedge core_clk);
        host_txd <= 1'b1;
    endtask : pulse
    // returns at mid stop bit; bounded wait for the start edge
    task automatic rx_byte(output logic [7:0] b, output bit ok);
        int n;
        n = 0;
        while (line === 1'b1 && n < 2000) begin
            @(posedge core_clk);
            n++;
        end
        ok = (n < 2000);
        repeat (BIT + BIT / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            b[i] = line;
            repeat (BIT) @(posedge core_clk);
        end
    endtask : rx_byte
endmodule : swu_host

// file: tb/swu_port_monitor.sv
// Purpose: port-level checker for swu_port
// Assumes: single core_clk domain
// Notes: bit time unknown here, so timing checks stay cycle-local
`timescale 1ns/1ps
module swu_port_monitor (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic line_out,
    input wire logic line_oe,
    input wire logic pdn_disable,
    input wire logic reg_power_down,
    input wire logic power_down,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire logic [7:0] write_count,
    input wire logic link_error
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    a_count_bump: assert property (wr_strobe |=> write_count == $past(write_count) + 8'h01)
        else $error("write count did not step");
    a_read_keeps: assert property (rd_strobe |=> $stable(write_count))
        else $error("read changed write count");
    a_count_cause: assert property ($changed(write_count) |-> $past(wr_strobe))
        else $error("write count moved without write");
    a_idle_high: assert property (!line_oe |-> line_out)
        else $error("line not high while released");
    a_reply_start: assert property ($rose(line_oe) |-> line_out ##1 line_out ##1 !line_out)
        else $error("reply start bit missing");
    a_turn_quiet: assert property (rd_strobe |-> (!line_oe)[*8])
        else $error("reply without turnaround");
    a_pdn_reg: assert property (pdn_disable |=> power_down == $past(reg_power_down))
        else $error("power down not from register");
    a_err_pulse: assert property (link_error |=> !link_error)
        else $error("error flag longer than a cycle");
    a_rw_excl: assert property (!(wr_strobe && rd_strobe))
        else $error("read and write together");
    c_wr: cover property (wr_strobe);
    c_rd: cover property (rd_strobe);
    c_err: cover property (link_error);
    c_release: cover property ($fell(line_oe));
endmodule : swu_port_monitor

bind swu_port swu_port_monitor swu_port_monitor_inst (.core_clk(core_clk), .arst_n(arst_n),
    .line_out(line_out), .line_oe(line_oe), .pdn_disable(pdn_disable), .reg_power_down(reg_power_down),
    .power_down(power_down), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .write_count(write_count),
    .link_error(link_error));

// file: tb/swu_port_tb.sv
// Purpose: self-checking bench for swu_port
// Assumes: bit time 40 cycles, node strapped to address 2
// Notes: errors only after the first good datagram, else recovery is huge
`timescale 1ns/1ps
module swu_port_tb;
    localparam int N = 40;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic host_txd, line_out, line_oe, power_down, wr_strobe, rd_strobe, link_error;
    logic pdn_disable = 1'b0, reg_power_down = 1'b0, address_strap_low = 1'b0, address_strap_high = 1'b1;
    logic [3:0] reply_turnaround_delay = 4'h1;
    logic [6:0] reg_addr;
    logic [31:0] wr_data, wd_q, exp_wd;
    logic [31:0] rd_data = 32'hCAFE0042;
    logic [7:0] write_count, exp_cnt = 8'h00;
    int errors = 0, check_count = 0, wr_n = 0, err_n = 0, t_rd = 0, t_oe = 0, cyc = 0;
    wire line = line_oe ? line_out : host_txd;
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (wr_strobe === 1'b1) wr_n <= wr_n + 1;
        if (wr_strobe === 1'b1) wd_q <= wr_data;
        if (link_error === 1'b1) err_n <= err_n + 1;
        if (rd_strobe === 1'b1) t_rd <= cyc;
        if (line_oe === 1'b1 && t_oe <= t_rd) t_oe <= cyc;
    end
    swu_port #(.BW(14), .TW(20)) swu_port_inst (.core_clk(core_clk), .arst_n(arst_n), .line_in(line),
        .line_out(line_out), .line_oe(line_oe), .address_strap_low(address_strap_low),
        .address_strap_high(address_strap_high), .reply_turnaround_delay(reply_turnaround_delay),
        .pdn_disable(pdn_disable), .reg_power_down(reg_power_down), .power_down(power_down),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .reg_addr(reg_addr), .wr_data(wr_data),
        .rd_data(rd_data), .write_count(write_count), .link_error(link_error));
    swu_host #(.BIT(N)) swu_host_inst (.core_clk(core_clk), .line(line), .host_txd(host_txd));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    task automatic t_pdn;
        pdn_disable <= 1'b1;
        reg_power_down <= 1'b1;
        repeat (3) @(posedge core_clk);
        check("pdn reg", power_down, 1'b1);
        pdn_disable <= 1'b0;
        repeat (3) @(posedge core_clk);
        check("pdn pin", power_down, 1'b0);
        $display("power down test done");
    endtask : t_pdn
    task automatic t_write(input logic [7:0] a, input logic [31:0] d, input bit bad);
        int w, e;
        bit hit;
        w = wr_n;
        e = err_n;
        hit = (a == 8'h02) && !bad;
        swu_host_inst.tx_dgram(a, 8'h90, d, bad);
        repeat (N) @(posedge core_clk);
        if (hit) exp_cnt = exp_cnt + 8'h01;
        if (hit) exp_wd = d;
        check("wr strobes", wr_n - w, hit ? 1 : 0);
        check("crc errors", err_n - e, bad ? 1 : 0);
        check("count", write_count, exp_cnt);
        check("data", wd_q, exp_wd);
        check("reg", reg_addr, 7'h10);
        if (bad) repeat (14 * N) @(posedge core_clk);
        $display("write test done");
    endtask : t_write
    task automatic t_read(input logic [3:0] dly);
        logic [7:0] q[$];
        logic [7:0] b, c;
        bit ok;
        reply_turnaround_delay <= dly;
        q = {8'h05, 8'hFF, 8'h10, rd_data[31:24], rd_data[23:16], rd_data[15:8], rd_data[7:0]};
        c = 8'h00;
        foreach (q[i]) c = swu_host_inst.crc(c, q[i]);
        q.push_back(c);
        swu_host_inst.tx_dgram(8'h02, 8'h10, 32'h0, 1'b0);
        foreach (q[i]) begin
            swu_host_inst.rx_byte(b, ok);
            check("reply byte", {ok, b}, {1'b1, q[i]});
        end
        check("turnaround", (t_oe - t_rd + 4) / 16, (dly == 4'h0 ? 1 : dly) * 8 * N / 16);
        repeat (4 * N) @(posedge core_clk);
        check("oe held", line_oe, 1'b1);
        repeat (N) @(posedge core_clk);
        check("oe released", line_oe, 1'b0);
        check("count", write_count, exp_cnt);
        $display("read test done");
    endtask : t_read
    task automatic t_errors;
        int e;
        e = err_n;
        swu_host_inst.tx_byte(8'h05);
        swu_host_inst.tx_byte(8'h02);
        repeat (52 * N) @(posedge core_clk);
        check("early timeout", err_n - e, 0);
        repeat (12 * N) @(posedge core_clk);
        check("timeout", err_n - e, 1);
        repeat (13 * N) @(posedge core_clk);
        swu_host_inst.pulse(8);
        repeat (2 * N) @(posedge core_clk);
        check("glitch", err_n - e, 2);
        repeat (13 * N) @(posedge core_clk);
        $display("error test done");
    endtask : t_errors
    initial begin
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (10) @(posedge core_clk);
        t_pdn();
        t_write(8'h02, 32'h12345678, 1'b0);
        t_write(8'h01, 32'hDEADBEEF, 1'b0);
        t_read(4'h0);
        t_read(4'h2);
        t_write(8'h02, 32'hA5A5A5A5, 1'b1);
        t_errors();
        t_write(8'h02, 32'h0000FFFF, 1'b0);
        finish_test();
    end
    initial begin
        repeat (100000) @(posedge core_clk);
        errors++;
        finish_test();
    end
endmodule : swu_port_tb
